// ---- capture_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Outside signal source on the capture pin
module capture_pin_model (
   // Clock
   input wire logic clk,
   // Pin into the timer
   output logic pin
);
   // Quiet line rests low
   initial pin = 1'b0;
   // Flip the pin after a gap, short or long
   task automatic flip(input int gap);
      repeat (gap) @(posedge clk);
      pin <= ~pin;
   endtask
endmodule // capture_pin_model
`default_nettype wire

// ---- counter_timer.v ----
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.vh"

// ==========================================
// Sixteen-bit counter/timer with APB slave
module counter_timer #(
   parameter MATCH_PINS = 3,
   parameter ADDR_W = 12
) (
   // Clock and reset
   input wire SYS_CLK,
   input wire RST_N,
   // APB slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [ADDR_W-1:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // Capture pin
   input wire CAPTURE_INPUT,
   // Match pins
   output reg [MATCH_PINS-1:0] MATCH_OUTPUTS
);

   // ==========================================
   // State
   reg [`FLAG_W-1:0] flags_r;
   reg [1:0] run_r;
   reg [`CNT_W-1:0] count_r;
   reg [`CNT_W-1:0] limit_r;
   reg [`CNT_W-1:0] pcount_r;
   reg [4*`MACT_W-1:0] mact_r;
   reg [`CNT_W-1:0] match_r [0:3];
   reg [2:0] capc_r;
   reg [`CNT_W-1:0] capv_r;
   reg [3:0] em_r;
   reg [7:0] emc_r;
   reg [3:0] src_r;
   reg [3:0] pwm_r;
   reg cap_s1_r;
   reg cap_s2_r;
   reg cap_s3_r;

   // ==========================================
   // Next values
   reg [`FLAG_W-1:0] flags_nxt;
   reg [1:0] run_nxt;
   reg [`CNT_W-1:0] count_nxt;
   reg [`CNT_W-1:0] pcount_nxt;
   reg [3:0] em_nxt;
   reg [3:0] hit;
   reg [`FLAG_W-1:0] flag_set;
   reg [`FLAG_W-1:0] flag_clr;
   reg [31:0] rdata_nxt;
   reg err_nxt;
   reg cnt_edge;
   reg any_rst;
   reg any_stop;
   integer i;
   integer j;

   // ==========================================
   // Bus strobes
   wire access = PSEL & PENABLE & PREADY;
   wire wr = access & PWRITE;
   wire [11:0] ofs = PADDR[11:0];

   // First access cycle, answered one edge later
   wire first_acc = PSEL & PENABLE & ~PREADY;

   // Write strobes of the registers that counting also changes
   wire wr_flags = wr & (ofs == `OFS_FLAGS);
   wire wr_run = wr & (ofs == `OFS_RUN);
   wire wr_count = wr & (ofs == `OFS_COUNT);
   wire wr_pcount = wr & (ofs == `OFS_PCOUNT);
   wire wr_outc = wr & (ofs == `OFS_OUTC);

   // Capture pin edges, read from second and third flops
   wire rise = cap_s2_r & ~cap_s3_r;
   wire fall = ~cap_s2_r & cap_s3_r;

   // Capture event qualified by enabled edges
   wire cap_evt = (capc_r[`CAPC_RISE] & rise) | (capc_r[`CAPC_FALL] & fall); // R9

   // Counting allowed: enabled and not held in reset
   wire running = run_r[`RUN_EN] & ~run_r[`RUN_HOLD]; // R4
   wire adv = running & cnt_edge;
   wire tick = adv & (pcount_r == limit_r); // R2

   // ==========================================
   // Count source selection
   always @* begin
      case (src_r[1:0]) // R12
         `SRC_TIMER: cnt_edge = 1'b1;
         `SRC_RISE: cnt_edge = rise; // R13
         `SRC_FALL: cnt_edge = fall; // R13
         default: cnt_edge = rise | fall; // R13
      endcase
   end

   // ==========================================
   // Match detection and actions
   always @* begin
      hit = 4'h0;
      any_rst = 1'b0;
      any_stop = 1'b0;
      flag_set = 5'h00;
      for (i = 0; i < 4; i = i + 1) begin
         hit[i] = tick & (count_r == match_r[i]); // R7
         if (hit[i] & mact_r[`MACT_W*i+`MACT_RST]) begin
            any_rst = 1'b1; // R7
         end
         if (hit[i] & mact_r[`MACT_W*i+`MACT_STOP]) begin
            any_stop = 1'b1; // R7
         end
         if (hit[i] & mact_r[`MACT_W*i+`MACT_INT]) begin
            flag_set[i] = 1'b1; // R7 R17
         end
      end
      if (cap_evt & capc_r[`CAPC_INT]) begin
         flag_set[`FLAG_CAP] = 1'b1; // R9 R17
      end
   end

   // ==========================================
   // Flag clear; a set in the same cycle wins
   always @* begin
      flag_clr = 5'h00;
      if (wr_flags) begin
         flag_clr = PWDATA[`FLAG_W-1:0]; // R6 R18
      end
      flags_nxt = (flags_r & ~flag_clr) | flag_set; // R20
   end

   // ==========================================
   // Prescaler and main count
   always @* begin
      count_nxt = count_r;
      pcount_nxt = pcount_r;
      if (run_r[`RUN_HOLD]) begin
         count_nxt = `ZERO16; // R4
         pcount_nxt = `ZERO16;
      end else if (tick) begin
         pcount_nxt = `ZERO16; // R2
         if (any_rst) begin
            count_nxt = `ZERO16; // R7
         end else if (any_stop) begin
            // Stop on match keeps the matched value
            count_nxt = count_r; // R7
         end else begin
            count_nxt = count_r + `ONE16; // R1 R19
         end
      end else if (adv) begin
         pcount_nxt = pcount_r + `ONE16; // R1
      end
      // Software writes take priority
      if (wr_count) begin
         count_nxt = PWDATA[`CNT_W-1:0];
      end
      if (wr_pcount) begin
         pcount_nxt = PWDATA[`CNT_W-1:0]; // R3
      end
   end

   // ==========================================
   // Run control, stop on match clears enable
   always @* begin
      run_nxt = run_r;
      if (any_stop) begin
         run_nxt[`RUN_EN] = 1'b0; // R7
      end
      if (wr_run) begin
         run_nxt = PWDATA[1:0]; // R4
      end
   end

   // ==========================================
   // Match output levels
   always @* begin
      em_nxt = em_r;
      for (j = 0; j < 4; j = j + 1) begin
         if (pwm_r[j]) begin
            // Low before the match point, high from it on
            em_nxt[j] = (count_r >= match_r[j]); // R14
         end else if (hit[j]) begin
            case (emc_r[2*j+:2]) // R10
               `OUT_LOW: em_nxt[j] = 1'b0;
               `OUT_HIGH: em_nxt[j] = 1'b1;
               `OUT_TOGGLE: em_nxt[j] = ~em_r[j];
               default: em_nxt[j] = em_r[j];
            endcase
         end
      end
      if (wr_outc) begin
         em_nxt = PWDATA[3:0];
      end
   end

   // ==========================================
   // Read data decode
   always @* begin
      rdata_nxt = `ZERO32;
      err_nxt = 1'b0;
      if (ofs == `OFS_FLAGS) begin
         rdata_nxt[`FLAG_W-1:0] = flags_r; // R5 R17
      end else if (ofs == `OFS_RUN) begin
         rdata_nxt[1:0] = run_r;
      end else if (ofs == `OFS_COUNT) begin
         rdata_nxt[`CNT_W-1:0] = count_r;
      end else if (ofs == `OFS_LIMIT) begin
         rdata_nxt[`CNT_W-1:0] = limit_r;
      end else if (ofs == `OFS_PCOUNT) begin
         rdata_nxt[`CNT_W-1:0] = pcount_r; // R3
      end else if (ofs == `OFS_MACT) begin
         rdata_nxt[4*`MACT_W-1:0] = mact_r;
      end else if (ofs == `OFS_MATCH0) begin
         rdata_nxt[`CNT_W-1:0] = match_r[0];
      end else if (ofs == `OFS_MATCH1) begin
         rdata_nxt[`CNT_W-1:0] = match_r[1];
      end else if (ofs == `OFS_MATCH2) begin
         rdata_nxt[`CNT_W-1:0] = match_r[2];
      end else if (ofs == `OFS_MATCH3) begin
         rdata_nxt[`CNT_W-1:0] = match_r[3];
      end else if (ofs == `OFS_CAPC) begin
         rdata_nxt[2:0] = capc_r;
      end else if (ofs == `OFS_CAPV) begin
         rdata_nxt[`CNT_W-1:0] = capv_r;
      end else if (ofs == `OFS_OUTC) begin
         rdata_nxt[11:0] = {emc_r, em_r};
      end else if (ofs == `OFS_SRC) begin
         rdata_nxt[3:0] = src_r;
      end else if (ofs == `OFS_PWM) begin
         rdata_nxt[3:0] = pwm_r;
      end else begin
         err_nxt = 1'b1;
      end
   end

   // ==========================================
   // APB handshake: one wait cycle per access
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= `ZERO32;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= first_acc;
         if (first_acc) begin
            PSLVERR <= err_nxt;
            if (!PWRITE) begin
               PRDATA <= rdata_nxt;
            end
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

   // ==========================================
   // Capture pin synchroniser and edge history
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         cap_s3_r <= 1'b0;
      end else begin
         cap_s1_r <= CAPTURE_INPUT;
         cap_s2_r <= cap_s1_r;
         cap_s3_r <= cap_s2_r;
      end
   end

   // ==========================================
   // Counting state and flags
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags_r <= 5'h00; // R16
         run_r <= 2'h0;
         count_r <= `ZERO16;
         pcount_r <= `ZERO16;
         em_r <= 4'h0;
      end else begin
         flags_r <= flags_nxt;
         run_r <= run_nxt;
         count_r <= count_nxt;
         pcount_r <= pcount_nxt;
         em_r <= em_nxt;
      end
   end

   // ==========================================
   // Capture register, loads even while stopped
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         capv_r <= `ZERO16; // R16
      end else if (cap_evt) begin
         capv_r <= count_r; // R8
      end
   end

   // ==========================================
   // Software configuration registers
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         limit_r <= `ZERO16; // R16
         mact_r <= 12'h000;
         match_r[0] <= `ZERO16;
         match_r[1] <= `ZERO16;
         match_r[2] <= `ZERO16;
         match_r[3] <= `ZERO16;
         capc_r <= 3'h0;
         emc_r <= 8'h00;
         src_r <= 4'h0;
         pwm_r <= 4'h0;
      end else if (wr) begin
         if (ofs == `OFS_LIMIT) begin
            limit_r <= PWDATA[`CNT_W-1:0];
         end else if (ofs == `OFS_MACT) begin
            mact_r <= PWDATA[4*`MACT_W-1:0];
         end else if (ofs == `OFS_MATCH0) begin
            match_r[0] <= PWDATA[`CNT_W-1:0];
         end else if (ofs == `OFS_MATCH1) begin
            match_r[1] <= PWDATA[`CNT_W-1:0];
         end else if (ofs == `OFS_MATCH2) begin
            match_r[2] <= PWDATA[`CNT_W-1:0];
         end else if (ofs == `OFS_MATCH3) begin
            match_r[3] <= PWDATA[`CNT_W-1:0];
         end else if (ofs == `OFS_CAPC) begin
            capc_r <= PWDATA[2:0]; // R9
         end else if (ofs == `OFS_OUTC) begin
            emc_r <= PWDATA[11:4]; // R10
         end else if (ofs == `OFS_SRC) begin
            src_r <= PWDATA[3:0]; // R12
         end else if (ofs == `OFS_PWM) begin
            pwm_r <= PWDATA[3:0]; // R14
         end
      end
   end

   // ==========================================
   // Match pins, only the pinned channels leave
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MATCH_OUTPUTS <= {MATCH_PINS{1'b0}};
      end else begin
         MATCH_OUTPUTS <= em_nxt[MATCH_PINS-1:0]; // R11
      end
   end

endmodule // counter_timer
`default_nettype wire

// ---- counter_timer_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.vh"
// ==========================================
// Port checks of the counter/timer
module counter_timer_assertions #(
   parameter MATCH_PINS = 3,
   parameter ADDR_W = 12
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // Bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Pins
   input wire logic CAPTURE_INPUT,
   input wire logic [MATCH_PINS-1:0] MATCH_OUTPUTS
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // Access phase and read completion
   wire logic acc = PSEL && PENABLE;
   wire logic rd = PREADY && !PWRITE;
   AST_ONE_WAIT: assert property (acc && !PREADY |=> PREADY)
      else $error("ready late");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   AST_READY_CAUSE: assert property ($rose(PREADY) |-> $past(acc))
      else $error("ready without access");
   AST_ERR_PAIR: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_RESET_ZERO: assert property ($rose(RST_N) |-> MATCH_OUTPUTS == 0 && PRDATA == 0)
      else $error("outputs not zero after reset");
   AST_GAP: assert property (rd && PADDR >= 12'h040 && PADDR <= 12'h06c |-> PSLVERR && PRDATA == 0)
      else $error("reserved offset answered");
   AST_COUNT_W: assert property (rd && PADDR == `OFS_COUNT |-> !PSLVERR && PRDATA[31:16] == 16'h0000)
      else $error("count wider than 16 bits");
   AST_FLAGS_RSVD: assert property (rd && PADDR == `OFS_FLAGS |-> PRDATA[31:5] == 27'h000_0000)
      else $error("flag reserved bits set");
endmodule // counter_timer_assertions
bind counter_timer counter_timer_assertions #(.MATCH_PINS(MATCH_PINS), .ADDR_W(ADDR_W)) chk_i (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CAPTURE_INPUT(CAPTURE_INPUT), .MATCH_OUTPUTS(MATCH_OUTPUTS));
`default_nettype wire

// ---- sixteen_bit_counter_timer_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.vh"
// ==========================================
// Self-checking bench of the counter/timer
module sixteen_bit_counter_timer_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic cap_pin;
   wire logic [2:0] mat;
   logic [31:0] rdata;
   logic rerr;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   counter_timer uut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CAPTURE_INPUT(cap_pin), .MATCH_OUTPUTS(mat));
   capture_pin_model cap (.clk(clk), .pin(cap_pin));
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         end_of_test();
      end
   end
   // Verdict
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask
   // One bus transfer, then one idle cycle
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string w, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(w, e, rdata);
   endtask
   // Count for a while, then stop
   task automatic run(input int n);
      wr(`OFS_RUN, 32'h0000_0001);
      repeat (n) @(posedge clk);
      wr(`OFS_RUN, 32'h0000_0000);
   endtask
   // Every offset reads zero; holes refuse
   task automatic t_reset;
      for (int a = 0; a < 'h78; a += 4) begin
         bus(1'b0, a[11:0], 32'h0000_0000);
         chk("reset value", 32'h0000_0000, rdata);
         chk("slave error", {31'h0000_0000, a >= 'h30 && a < 'h70 && a != 'h3c}, {31'h0000_0000, rerr});
      end
   endtask
   // Prescaler pacing and access
   task automatic t_prescale;
      logic [31:0] tot;
      wr(`OFS_PCOUNT, 32'h0000_0002);
      rc("prescale count", `OFS_PCOUNT, 32'h0000_0002);
      wr(`OFS_LIMIT, 32'h0000_0003);
      wr(`OFS_PCOUNT, 32'h0000_0000);
      run(40);
      bus(1'b0, `OFS_PCOUNT, 32'h0000_0000);
      chk("prescale in range", 32'h0000_0001, {31'h0000_0000, rdata <= 32'h0000_0003});
      tot = rdata;
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      tot = tot + rdata * 4;
      chk("elapsed ticks", 32'h0000_0001, {31'h0000_0000, tot >= 42 && tot <= 46});
      wr(`OFS_LIMIT, 32'h0000_0000);
      wr(`OFS_RUN, 32'h0000_0003);
      repeat (8) @(posedge clk);
      rc("held count", `OFS_COUNT, 32'h0000_0000);
      wr(`OFS_RUN, 32'h0000_0000);
   endtask
   // Match reset, stop and flags
   task automatic t_match;
      wr(`OFS_MATCH0, 32'h0000_0002);
      wr(`OFS_MACT, 32'h0000_0003);
      run(20);
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      chk("reset on match", 32'h0000_0001, {31'h0000_0000, rdata <= 32'h0000_0002});
      wr(`OFS_COUNT, 32'h0000_0009);
      rc("flags", `OFS_FLAGS, 32'h0000_0001);
      wr(`OFS_FLAGS, 32'h0000_0000);
      rc("flags", `OFS_FLAGS, 32'h0000_0001);
      wr(`OFS_FLAGS, 32'h0000_0001);
      rc("flags", `OFS_FLAGS, 32'h0000_0000);
      wr(`OFS_MATCH1, 32'h0000_0005);
      wr(`OFS_MACT, 32'h0000_0028);
      wr(`OFS_COUNT, 32'h0000_0000);
      wr(`OFS_RUN, 32'h0000_0001);
      repeat (20) @(posedge clk);
      rc("stopped run", `OFS_RUN, 32'h0000_0000);
      rc("stopped count", `OFS_COUNT, 32'h0000_0005);
      rc("flags", `OFS_FLAGS, 32'h0000_0002);
      wr(`OFS_FLAGS, 32'h0000_001f);
      wr(`OFS_MACT, 32'h0000_0000);
      wr(`OFS_COUNT, 32'h0000_fffe);
      run(10);
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      chk("wrapped", 32'h0000_0001, {31'h0000_0000, rdata < 32'h0000_0020});
   endtask
   // Capture on chosen edges
   task automatic t_capture;
      wr(`OFS_COUNT, 32'h0000_1234);
      wr(`OFS_CAPC, 32'h0000_0005);
      cap.flip(1);
      cap.flip(8);
      repeat (8) @(posedge clk);
      wr(`OFS_CAPV, 32'h0000_ffff);
      rc("capture", `OFS_CAPV, 32'h0000_1234);
      rc("flags", `OFS_FLAGS, 32'h0000_0010);
      wr(`OFS_FLAGS, 32'h0000_0010);
      wr(`OFS_CAPC, 32'h0000_0002);
      wr(`OFS_COUNT, 32'h0000_0555);
      cap.flip(1);
      repeat (8) @(posedge clk);
      rc("capture", `OFS_CAPV, 32'h0000_1234);
      cap.flip(1);
      repeat (8) @(posedge clk);
      rc("capture", `OFS_CAPV, 32'h0000_0555);
      rc("flags", `OFS_FLAGS, 32'h0000_0000);
   endtask
   // Match pin actions, counter mode, pwm
   task automatic t_pins;
      logic [5:0] act [4] = '{6'h20, 6'h11, 6'h30, 6'h01};
      logic [31:0] cnt [3] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0006};
      wr(`OFS_MATCH0, 32'h0000_0003);
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_COUNT, 32'h0000_0000);
         wr(`OFS_OUTC, {26'h000_0000, act[i]});
         run(6);
         chk("match pins", {31'h0000_0000, i != 1}, {29'h0000_0000, mat});
      end
      wr(`OFS_OUTC, 32'h0000_0000);
      for (int m = 1; m < 4; m++) begin
         wr(`OFS_SRC, m);
         wr(`OFS_COUNT, 32'h0000_0000);
         wr(`OFS_RUN, 32'h0000_0001);
         repeat (6) cap.flip(3);
         repeat (8) @(posedge clk);
         rc("edge count", `OFS_COUNT, cnt[m-1]);
      end
      wr(`OFS_SRC, 32'h0000_0000);
      wr(`OFS_RUN, 32'h0000_0000);
      wr(`OFS_MATCH3, 32'h0000_0008);
      wr(`OFS_MACT, 32'h0000_0400);
      wr(`OFS_MATCH0, 32'h0000_0004);
      wr(`OFS_PWM, 32'h0000_0001);
      wr(`OFS_COUNT, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk("pwm low", 32'h0000_0000, {29'h0000_0000, mat});
      wr(`OFS_COUNT, 32'h0000_0006);
      repeat (2) @(posedge clk);
      chk("pwm high", 32'h0000_0001, {29'h0000_0000, mat});
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_prescale();
      t_match();
      t_capture();
      t_pins();
      end_of_test();
   end
endmodule // sixteen_bit_counter_timer_tb_top
`default_nettype wire

// ---- timer_defs.vh ----
// Functional notes
// R1: Count advances every prescale_limit plus one cycles
// R2: Prescale terminal value increments count, clears prescaler
// R3: Prescale counter is 16 bits, readable and writable
// R4: Run control can disable or hold count reset
// R5: Flags register reports five pending interrupt sources
// R6: Writing flags clears the selected pending flags
// R7: Match can reset, stop, or flag per channel
// R8: Capture event loads capture value from count
// R9: Capture control picks edges and capture flag
// R10: Match drives output low, high, toggle, or nothing
// R11: Unit zero three match pins, unit one two
// R12: Source control picks timer or counter mode edges
// R13: Capture input may clock the count instead
// R14: PWM mode gives single-edge PWM per output
// R15: Software should set period with unpinned match
// R16: All used register bits read zero after reset
// R17: Flag bits 3:0 match, bit 4 capture
// R18: Write one clears flag, zero leaves it
// R19: Count wraps from all ones to zero
// R20: Match flags stay set until software clears
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ==========================================
// Register offsets (byte addresses)
`define OFS_FLAGS 12'h000
`define OFS_RUN 12'h004
`define OFS_COUNT 12'h008
`define OFS_LIMIT 12'h00c
`define OFS_PCOUNT 12'h010
`define OFS_MACT 12'h014
`define OFS_MATCH0 12'h018
`define OFS_MATCH1 12'h01c
`define OFS_MATCH2 12'h020
`define OFS_MATCH3 12'h024
`define OFS_CAPC 12'h028
`define OFS_CAPV 12'h02c
`define OFS_OUTC 12'h03c
`define OFS_SRC 12'h070
`define OFS_PWM 12'h074

// ==========================================
// Widths and reset values
`define CNT_W 16
`define FLAG_W 5
`define ZERO16 16'h0000
`define ONE16 16'h0001
`define ZERO32 32'h0000_0000

// ==========================================
// Field positions
`define FLAG_CAP 4
`define RUN_EN 0
`define RUN_HOLD 1
`define MACT_INT 0
`define MACT_RST 1
`define MACT_STOP 2
`define MACT_W 3
`define CAPC_RISE 0
`define CAPC_FALL 1
`define CAPC_INT 2

// ==========================================
// Mode encodings
`define SRC_TIMER 2'h0
`define SRC_RISE 2'h1
`define SRC_FALL 2'h2
`define SRC_BOTH 2'h3
`define OUT_NONE 2'h0
`define OUT_LOW 2'h1
`define OUT_HIGH 2'h2
`define OUT_TOGGLE 2'h3

`endif
